// ===== hw/ccaa_consts.vh
`ifndef CCAA_CONSTS_VH
`define CCAA_CONSTS_VH

// Register offsets
`define CCAA_ADDR_W 6
`define CCAA_OFS_STATE 6'h01
`define CCAA_OFS_CTRL 6'h08
`define CCAA_OFS_THRES 6'h09

// Field positions
`define CCAA_STATE_DONE_BIT 7
`define CCAA_STATE_IDLE_BIT 6
`define CCAA_CTRL_REQ_BIT 7
`define CCAA_CTRL_MODE_HI 6
`define CCAA_CTRL_MODE_LO 5
`define CCAA_THRES_HI 4
`define CCAA_THRES_LO 0

// Reset values
`define CCAA_CTRL_RESET 8'h2b
`define CCAA_THRES_RESET 8'hc7

// Assessment modes
`define CCAA_MODE_OR 2'h0
`define CCAA_MODE_ENERGY 2'h1
`define CCAA_MODE_CARRIER 2'h2
`define CCAA_MODE_AND 2'h3

// Signal floor in dBm; a signal strength code of 1 stands at this level
`define CCAA_FLOOR_DBM (-91)

// Timing
`define CCAA_CLK_MHZ 100
`define CCAA_MEAS_TIME_US 128
`define CCAA_RESULT_TIME_US 140
`define CCAA_MEAS_CYCLES (`CCAA_MEAS_TIME_US * `CCAA_CLK_MHZ)
`define CCAA_RESULT_CYCLES (`CCAA_RESULT_TIME_US * `CCAA_CLK_MHZ)

`endif

// ===== hw/ccaa_energy_win.v
`timescale 1ns/100ps
`include "ccaa_consts.vh"

module ccaa_energy_win #(
   parameter WIN_CYCLES = `CCAA_MEAS_CYCLES,
   parameter CNT_W = 16,
   parameter NUM_W = 8
) (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Control
   input wire start,
   input wire [4:0] thres_field,
   // Signal strength samples
   input wire rssi_strobe,
   input wire [4:0] rssi_value,
   // Result
   output reg running,
   output reg done,
   output reg above
);

reg [CNT_W-1:0] cnt_reg;
reg [NUM_W+4:0] sum_reg;
reg [NUM_W-1:0] num_reg;
wire [NUM_W+7:0] lhs;
wire [NUM_W+7:0] rhs;
wire [NUM_W+7:0] coef;
wire last;

// Mean power above floor is 3*(avg-1) dB; compare against 2*thres without dividing
assign lhs = {3'h0, sum_reg} + {2'h0, sum_reg, 1'b0};
// Coefficient 2*thres+3: the +3 puts the floor at code 1, kept at full width
assign coef = {{(NUM_W+2){1'b0}}, thres_field, 1'b1} + {{(NUM_W+6){1'b0}}, 2'b10};
assign rhs = coef * {8'h00, num_reg};
assign last = (cnt_reg == WIN_CYCLES - 1);

// Window counter and accumulator; a start while running restarts the window
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      cnt_reg <= {CNT_W{1'b0}};
      sum_reg <= {(NUM_W+5){1'b0}};
      num_reg <= {NUM_W{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
      above <= 1'b0;
   end
   else
   begin
      done <= 1'b0;
      if (start)
      begin
         cnt_reg <= {CNT_W{1'b0}};
         sum_reg <= {(NUM_W+5){1'b0}};
         num_reg <= {NUM_W{1'b0}};
         running <= 1'b1;
      end
      else if (running)
      begin
         cnt_reg <= cnt_reg + 1'b1;
         if (rssi_strobe && !last)
         begin
            sum_reg <= sum_reg + {{NUM_W{1'b0}}, rssi_value};
            num_reg <= num_reg + 1'b1;
         end
         if (last)
         begin
            running <= 1'b0;
            done <= 1'b1;
            above <= (num_reg != {NUM_W{1'b0}}) && (lhs > rhs);
         end
      end
   end
end

endmodule // ccaa_energy_win

// ===== hw/ccaa_regs.v
`timescale 1ns/100ps
`include "ccaa_consts.vh"

module ccaa_regs (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [5:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Status in
   input wire done_flag,
   input wire idle_flag,
   input wire [4:0] trx_state_code,
   // Controls out
   output wire req_pulse,
   output wire [1:0] req_mode,
   output wire [1:0] mode_field,
   output wire [4:0] thres_field
);

reg [6:0] ctrl_reg;
reg [7:0] thres_reg;
wire wr_ctrl;
localparam [7:0] CTRL_RST = `CCAA_CTRL_RESET;

assign wr_ctrl = reg_wr && (reg_addr == `CCAA_OFS_CTRL);
// Request bit is never stored, so it always reads back as zero
assign req_pulse = wr_ctrl && reg_wdata[`CCAA_CTRL_REQ_BIT];
assign req_mode = reg_wdata[`CCAA_CTRL_MODE_HI:`CCAA_CTRL_MODE_LO];
assign mode_field = ctrl_reg[`CCAA_CTRL_MODE_HI:`CCAA_CTRL_MODE_LO];
assign thres_field = thres_reg[`CCAA_THRES_HI:`CCAA_THRES_LO];

// Writable registers
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      ctrl_reg <= CTRL_RST[6:0];
      thres_reg <= `CCAA_THRES_RESET;
   end
   else
   begin
      if (wr_ctrl)
         ctrl_reg <= reg_wdata[6:0];
      if (reg_wr && (reg_addr == `CCAA_OFS_THRES))
         thres_reg <= reg_wdata;
   end
end

// Read data registered on the read strobe; unmapped offsets read zero
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
      reg_rdata <= 8'h00;
   else if (reg_rd)
   begin
      case (reg_addr)
         `CCAA_OFS_STATE: reg_rdata <= {done_flag, idle_flag, 1'b0, trx_state_code};
         `CCAA_OFS_CTRL: reg_rdata <= {1'b0, ctrl_reg};
         `CCAA_OFS_THRES: reg_rdata <= thres_reg;
         default: reg_rdata <= 8'h00;
      endcase
   end
end

endmodule // ccaa_regs

// ===== hw/ccaa_clear_channel.v
// What this block does
// - Mode 1 reports busy when measured energy exceeds the threshold.
// - Mode 2 reports busy only when a compliant carrier is detected.
// - Mode 0 ORs carrier and energy results; mode 3 ANDs them.
// - Writing the request bit in a basic receive state starts an assessment.
// - In listening state, result appears 140 us after request, 128 us window.
// - Every manual assessment ends with the shared measurement-done interrupt.
// - Threshold is floor plus twice the threshold field, in dBm.
// - A request clears the complete and idle flags at once.
// - Finish sets complete; idle is set only if the mode's busy condition was not met.
// - Carrier sense reports busy on compliant signals above the floor.
// - Request outside basic receive state: interrupt and complete, no measurement.
// - Frame-state request during energy window, modes 1, 3, 0: early interrupt, second at finish.
// - Frame state, modes 1, 3, 0: finish at window end, else at once.
// - Frame state, mode 2: result is available immediately.
// - One automatic 8-symbol energy window per frame after sync header.
// - Preamble detect disable keeps listening state; host should assess there.
// - Complete flag is bit 7 of the transceiver state register.
// - Signal floor for threshold and carrier comparisons is -91 dBm.
// - Idle flag is bit 6 of transceiver state; 1 means idle.
// - Request is bit 7 of control and self-clears; mode is bits 6:5.
// - Threshold field is bits 4:0 of the threshold register.
`timescale 1ns/100ps
`include "ccaa_consts.vh"

module ccaa_clear_channel #(
   parameter MEAS_CYCLES = `CCAA_MEAS_CYCLES,
   parameter RESULT_CYCLES = `CCAA_RESULT_CYCLES,
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Register port from the serial interface
   input wire reg_wr,
   input wire reg_rd,
   input wire [5:0] reg_addr,
   input wire [7:0] reg_wdata,
   output wire [7:0] reg_rdata,
   // Transceiver state
   input wire [4:0] trx_state_code,
   input wire rx_listen,
   input wire rx_frame,
   input wire ext_mode,
   input wire preamble_detect_disable_bit,
   // Receiver observations
   input wire rssi_strobe,
   input wire [4:0] rssi_value,
   input wire carrier_detect,
   input wire shr_detect,
   // Shared measurement-done interrupt
   input wire ed_done_evt,
   output wire measurement_done_interrupt,
   // Status outputs
   output wire assessment_complete_flag,
   output wire channel_idle_flag,
   output wire assess_active
);

// One-hot states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_LISTEN = 3'b010;
localparam [2:0] ST_WAIT_AUTO = 3'b100;

// Sequencer state, captured mode and result counter
reg [2:0] state_reg;
reg [2:0] state_next;
reg [1:0] mode_reg;
reg [1:0] mode_next;
reg [CNT_W-1:0] res_cnt_reg;
reg [CNT_W-1:0] res_cnt_next;

// Carrier seen during the current assessment
reg cs_seen_reg;
reg cs_seen_next;

// Status flags and the registered interrupt pulse
reg done_reg;
reg done_next;
reg idle_reg;
reg idle_next;
reg irq_reg;

// Automatic window bookkeeping
reg auto_armed_reg;
reg auto_above_reg;

// One-cycle events decoded by the sequencer
reg fin;
reg fin_idle;
reg early_irq;
reg man_start;

// Register file outputs
wire req_pulse;
wire [1:0] req_mode;
wire [1:0] mode_field;
wire [4:0] thres_field;

// Request qualification and window status
wire basic_rx;
wire req_accept;
wire auto_start;
wire auto_running;
wire auto_done;
wire auto_above;
wire man_running;
wire man_done;
wire man_above;
wire in_window;
wire res_last;

// Mode combine: returns 1 for a busy channel
function busy_of;
   input [1:0] mode;
   input cs;
   input en;
   begin
      case (mode)
         `CCAA_MODE_OR: busy_of = cs | en;
         `CCAA_MODE_ENERGY: busy_of = en;
         `CCAA_MODE_CARRIER: busy_of = cs;
         `CCAA_MODE_AND: busy_of = cs & en;
         default: busy_of = 1'b1;
      endcase
   end
endfunction

// Register file
ccaa_regs u_regs (
   .ref_clk(ref_clk),
   .rstn(rstn),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .done_flag(done_reg),
   .idle_flag(idle_reg),
   .trx_state_code(trx_state_code),
   .req_pulse(req_pulse),
   .req_mode(req_mode),
   .mode_field(mode_field),
   .thres_field(thres_field)
);

// Manual energy window used in listening state
ccaa_energy_win #(
   .WIN_CYCLES(MEAS_CYCLES),
   .CNT_W(CNT_W),
   .NUM_W(8)
) u_man_win (
   .ref_clk(ref_clk),
   .rstn(rstn),
   .start(man_start),
   .thres_field(thres_field),
   .rssi_strobe(rssi_strobe),
   .rssi_value(rssi_value),
   .running(man_running),
   .done(man_done),
   .above(man_above)
);

// Automatic energy window started by a sync header
ccaa_energy_win #(
   .WIN_CYCLES(MEAS_CYCLES),
   .CNT_W(CNT_W),
   .NUM_W(8)
) u_auto_win (
   .ref_clk(ref_clk),
   .rstn(rstn),
   .start(auto_start),
   .thres_field(thres_field),
   .rssi_strobe(rssi_strobe),
   .rssi_value(rssi_value),
   .running(auto_running),
   .done(auto_done),
   .above(auto_above)
);

// Basic-mode receive states only; extended mode counts as outside
assign basic_rx = (rx_listen | rx_frame) & ~ext_mode;
// A request while one is running is dropped, keeping the captured mode intact
assign req_accept = req_pulse && (state_reg == ST_IDLE);
// With preamble detection off no frame can start, so no automatic window
assign auto_start = shr_detect & auto_armed_reg & ~preamble_detect_disable_bit;
assign in_window = (res_cnt_reg < MEAS_CYCLES);
assign res_last = (res_cnt_reg == RESULT_CYCLES - 1);

// Automatic window bookkeeping: armed between frames, one window per frame
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      auto_armed_reg <= 1'b1;
      auto_above_reg <= 1'b0;
   end
   else
   begin
      if (auto_start)
         auto_armed_reg <= 1'b0;
      else if (!rx_frame)
         auto_armed_reg <= 1'b1;
      if (auto_done)
         auto_above_reg <= auto_above;
   end
end

// Sequencer next-state logic
always @*
begin
   state_next = state_reg;
   mode_next = mode_reg;
   res_cnt_next = res_cnt_reg;
   cs_seen_next = cs_seen_reg;
   fin = 1'b0;
   fin_idle = 1'b0;
   early_irq = 1'b0;
   man_start = 1'b0;
   case (state_reg)
      ST_IDLE:
      begin
         if (req_accept)
         begin
            mode_next = req_mode;
            if (!basic_rx)
            begin
               // No measurement; complete set, idle left cleared
               fin = 1'b1;
               fin_idle = 1'b0;
            end
            else if (rx_listen)
            begin
               // Full window followed by processing delay
               state_next = ST_LISTEN;
               man_start = 1'b1;
               res_cnt_next = {CNT_W{1'b0}};
               cs_seen_next = carrier_detect;
            end
            else if (req_mode == `CCAA_MODE_CARRIER)
            begin
               fin = 1'b1;
               fin_idle = ~carrier_detect;
            end
            else if (auto_running)
            begin
               // Result waits for the frame's energy window to close
               state_next = ST_WAIT_AUTO;
               early_irq = 1'b1;
               // Carrier history restarts so an older assessment cannot leak in
               cs_seen_next = carrier_detect;
            end
            else
            begin
               fin = 1'b1;
               fin_idle = ~busy_of(req_mode, carrier_detect, auto_above_reg);
            end
         end
      end
      ST_LISTEN:
      begin
         res_cnt_next = res_cnt_reg + 1'b1;
         // Carrier only counts inside the energy window, not the processing tail
         if (in_window && carrier_detect)
            cs_seen_next = 1'b1;
         if (res_last)
         begin
            state_next = ST_IDLE;
            fin = 1'b1;
            fin_idle = ~busy_of(mode_reg, cs_seen_reg, man_above);
         end
      end
      ST_WAIT_AUTO:
      begin
         // Carrier is gathered until the frame's window closes
         if (carrier_detect)
            cs_seen_next = 1'b1;
         if (auto_done)
         begin
            state_next = ST_IDLE;
            fin = 1'b1;
            fin_idle = ~busy_of(mode_reg, cs_seen_reg | carrier_detect, auto_above);
         end
      end
      default:
      begin
         // Illegal codes fall back to idle; flags keep their last value
         state_next = ST_IDLE;
      end
   endcase
end

// Flag next values: a finish in the same cycle as a clear wins
always @*
begin
   done_next = done_reg;
   idle_next = idle_reg;
   if (req_accept)
   begin
      done_next = 1'b0;
      idle_next = 1'b0;
   end
   if (fin)
   begin
      done_next = 1'b1;
      idle_next = fin_idle;
   end
end

// Sequencer and flag registers
always @(posedge ref_clk or negedge rstn)
begin
   if (!rstn)
   begin
      state_reg <= ST_IDLE;
      mode_reg <= `CCAA_MODE_ENERGY;
      res_cnt_reg <= {CNT_W{1'b0}};
      cs_seen_reg <= 1'b0;
      done_reg <= 1'b0;
      idle_reg <= 1'b0;
      irq_reg <= 1'b0;
   end
   else
   begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      res_cnt_reg <= res_cnt_next;
      cs_seen_reg <= cs_seen_next;
      done_reg <= done_next;
      idle_reg <= idle_next;
      // Interrupt is shared with manual energy measurements
      irq_reg <= fin | early_irq | ed_done_evt;
   end
end

// Outputs
assign measurement_done_interrupt = irq_reg;
assign assessment_complete_flag = done_reg;
assign channel_idle_flag = idle_reg;
assign assess_active = (state_reg != ST_IDLE);

endmodule // ccaa_clear_channel

// ===== tb/ccaa_monitor.sv
`timescale 1ns/100ps
module ccaa_monitor #(
   parameter int RESULT_CYCLES = 50
) (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [5:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // Receiver side
   input wire [4:0] trx_state_code,
   input wire rx_listen,
   input wire rx_frame,
   input wire ext_mode,
   input wire carrier_detect,
   // Results
   input wire measurement_done_interrupt,
   input wire assessment_complete_flag,
   input wire channel_idle_flag,
   input wire assess_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Accepted requests by receiver state; busy-time writes are not requests
   wire req = reg_wr && reg_addr == 6'h08 && reg_wdata[7] && !assess_active;
   wire lreq = req && rx_listen && !ext_mode;
   wire oreq = req && (ext_mode || !(rx_listen || rx_frame));
   wire creq = req && rx_frame && !rx_listen && !ext_mode && reg_wdata[6:5] == 2'h2;

   a_req_clears_flags: assert property (lreq |=> !assessment_complete_flag && !channel_idle_flag)
      else $error("flags not cleared by request");
   a_listen_wait: assert property (lreq |=> (!measurement_done_interrupt && assess_active)[*8])
      else $error("listen assessment ended early");
   a_listen_result: assert property (lreq |=> ##RESULT_CYCLES measurement_done_interrupt && assessment_complete_flag)
      else $error("listen result not on time");
   a_outside_rx: assert property (oreq |=> assessment_complete_flag && !channel_idle_flag && measurement_done_interrupt)
      else $error("no immediate completion outside receive");
   a_frame_carrier: assert property (creq |=> assessment_complete_flag && channel_idle_flag != $past(carrier_detect))
      else $error("carrier mode not immediate in frame");
   a_done_has_irq: assert property ($rose(assessment_complete_flag) |-> measurement_done_interrupt)
      else $error("completion without interrupt");
   a_idle_needs_done: assert property (channel_idle_flag |-> assessment_complete_flag)
      else $error("idle shown before completion");
   a_state_readback: assert property (reg_rd && reg_addr == 6'h01 |=> reg_rdata == {$past(assessment_complete_flag), $past(channel_idle_flag), 1'b0, $past(trx_state_code)})
      else $error("state register read wrong");
endmodule // ccaa_monitor

bind ccaa_clear_channel ccaa_monitor #(.RESULT_CYCLES(RESULT_CYCLES)) mon_u (.ref_clk, .rstn,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .trx_state_code, .rx_listen, .rx_frame,
   .ext_mode, .carrier_detect, .measurement_done_interrupt, .assessment_complete_flag,
   .channel_idle_flag, .assess_active);

// ===== tb/ccaa_rx_model.sv
`timescale 1ns/100ps
module ccaa_rx_model (
   // Clock and reset
   input wire ref_clk,
   input wire rstn,
   // Channel set by the bench
   input wire [4:0] level,
   input wire carrier_in,
   // Receiver observations
   output logic rssi_strobe,
   output logic [4:0] rssi_value,
   output wire carrier_detect
);
   logic [1:0] div_reg;
   // Sample every fourth cycle; scrambled between samples so stale values never pass
   always @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         div_reg <= 2'h0;
         rssi_strobe <= 1'b0;
         rssi_value <= 5'h00;
      end
      else
      begin
         div_reg <= div_reg + 2'h1;
         rssi_strobe <= &div_reg;
         rssi_value <= &div_reg ? level : ~level;
      end
   assign carrier_detect = carrier_in;
endmodule // ccaa_rx_model

// ===== tb/test_clear_channel_assessment.sv
`timescale 1ns/100ps
module test_clear_channel_assessment;
   logic ref_clk, rstn, reg_wr, reg_rd, rx_listen, rx_frame, pdd, shr_detect, carrier;
   logic rssi_strobe, carrier_detect, irq, done, idle, active;
   logic ext, edv;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_val;
   logic [4:0] trx, level, rssi_value, th;
   int errors, comparisons, cycles, seed, m, n, t0, e;

   // Design with shortened measurement counts
   ccaa_clear_channel #(.MEAS_CYCLES(40), .RESULT_CYCLES(50)) dut_u (.ref_clk, .rstn, .reg_wr,
      .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .trx_state_code(trx), .rx_listen, .rx_frame,
      .ext_mode(ext), .preamble_detect_disable_bit(pdd), .rssi_strobe, .rssi_value,
      .carrier_detect, .shr_detect, .ed_done_evt(edv), .measurement_done_interrupt(irq),
      .assessment_complete_flag(done), .channel_idle_flag(idle), .assess_active(active));

   // Receiver stand-in
   ccaa_rx_model rx_u (.ref_clk, .rstn, .level, .carrier_in(carrier), .rssi_strobe,
      .rssi_value, .carrier_detect);

   // Report and end the run
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Compare one value
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Register write; returns just after the taking edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Register read into rd_val
   task automatic rd(input logic [5:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk) #1;
      rd_val = reg_rdata;
   endtask

   // Bench model of the idle decision
   function automatic int model_idle(int mode, int c, int en);
      case (mode)
         0: return !(c || en);
         1: return !en;
         2: return !c;
         default: return !(c && en);
      endcase
   endfunction

   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Cut a hang short
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   // Main sequence
   initial
   begin
      seed = 32'h6a24;
      {reg_wr, reg_rd, rx_listen, rx_frame, pdd, shr_detect, carrier} = 7'h00;
      {ext, edv} = 2'h0;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
      level = 5'h00;
      trx = $random(seed);
      rstn = 1'b0;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(6'h08);
      chk("control", rd_val, 8'h2b);
      rd(6'h09);
      chk("threshold", rd_val, 8'hc7);
      wr(6'h01, 8'hff);
      rd(6'h01);
      chk("state", rd_val, {3'h0, trx});
      rd(6'h3f);
      chk("unmapped", rd_val, 8'h00);
      // Listening state, every mode, random channel
      rx_listen <= 1'b1;
      pdd <= 1'b1;
      for (m = 0; m < 4; m++)
      begin
         level <= 5'({$random(seed)} % 29);
         carrier <= $random(seed);
         th = $random(seed);
         wr(6'h09, {3'h6, th});
         wr(6'h08, {1'b1, 2'(m), 5'h0b});
         #1;
         t0 = cycles;
         e = 3 * level > 2 * th + 3;
         chk("cleared", {done, idle}, 8'h00);
         wr(6'h08, {1'b0, 2'(~m), 5'h0b});
         n = 0;
         while (irq !== 1'b1 && n < 100)
         begin
            @(posedge ref_clk) #1;
            n++;
         end
         chk("latency", 8'(cycles - t0), 8'd50);
         chk("result", {done, idle}, {1'b1, 1'(model_idle(m, carrier, e))});
         rd(6'h08);
         chk("control", rd_val, {1'b0, 2'(~m), 5'h0b});
      end
      // Outside any receive state completion is immediate
      rx_listen <= 1'b0;
      wr(6'h08, 8'h80);
      #1;
      chk("no receive", {irq, done, idle}, 8'h06);
      // Extended mode counts as outside a basic receive state
      rx_listen <= 1'b1;
      ext <= 1'b1;
      wr(6'h08, 8'h80);
      #1;
      chk("extended", {irq, done, idle}, 8'h06);
      // Back to basic mode; a manual energy done shares the interrupt
      rx_listen <= 1'b0;
      ext <= 1'b0;
      edv <= 1'b1;
      @(posedge ref_clk);
      edv <= 1'b0;
      #1;
      chk("shared irq", irq, 8'h01);
      // Frame reception with the automatic energy window running
      rx_frame <= 1'b1;
      pdd <= 1'b0;
      @(posedge ref_clk);
      shr_detect <= 1'b1;
      @(posedge ref_clk);
      shr_detect <= 1'b0;
      wr(6'h08, 8'ha0);
      #1;
      chk("early", {irq, done}, 8'h02);
      n = 0;
      while (done !== 1'b1 && n < 100)
      begin
         @(posedge ref_clk) #1;
         n++;
      end
      chk("late", {irq, idle}, {1'b1, 1'(model_idle(1, carrier, e))});
      wr(6'h08, 8'ha0);
      #1;
      chk("after window", {irq, done, idle}, {2'b11, 1'(e == 0)});
      carrier <= 1'b1;
      wr(6'h08, 8'hc0);
      #1;
      chk("carrier", {irq, done, idle}, 8'h06);
      tally_and_finish();
   end
endmodule // test_clear_channel_assessment
